// [sep_pkg.sv]
// Constants, opcodes, status layout and timing for the SPI EEPROM command block.
// Assumes a 25 MHz system clock and an SPI master running modes 0 or 3.
package sep_pkg;

  // Command opcodes, sent MSB first.
  localparam logic [7:0] OP_SET_WE    = 8'h06;
  localparam logic [7:0] OP_CLR_WE    = 8'h04;
  localparam logic [7:0] OP_SET_FLAG  = 8'h00;
  localparam logic [7:0] OP_STAT_RD   = 8'h05;
  localparam logic [7:0] OP_STAT_WR   = 8'h01;
  localparam logic [7:0] OP_READ      = 8'h03;
  localparam logic [7:0] OP_WRITE     = 8'h02;

  // Status byte field positions.
  localparam int ST_LOCK    = 7;
  localparam int ST_FLAG    = 6;
  localparam int ST_WD_HI   = 5;
  localparam int ST_WD_LO   = 4;
  localparam int ST_BP_HI   = 3;
  localparam int ST_BP_LO   = 2;
  localparam int ST_WEL     = 1;
  localparam int ST_BUSY    = 0;
  localparam int WD_W       = 2;

  // Values the nonvolatile status bits take after reset.
  localparam logic         NV_LOCK_RST = 1'b0;
  localparam logic [1:0]   NV_WD_RST   = 2'h0;
  localparam logic [1:0]   NV_BP_RST   = 2'h0;

  // Array geometry and guarded ranges.
  localparam int           ARRAY_ADDR_W   = 13;
  localparam int           PAGE_ADDR_W    = 5;
  localparam logic [15:0]  PROT_QTR_BASE  = 16'h1800;
  localparam logic [15:0]  PROT_HALF_BASE = 16'h1000;

  // Frame phases counted in whole bytes, and the last bit of a byte.
  localparam logic [1:0]   PH_OPCODE  = 2'h0;
  localparam logic [1:0]   PH_ADDR_HI = 2'h1;
  localparam logic [1:0]   PH_ADDR_LO = 2'h2;
  localparam logic [1:0]   PH_DATA    = 2'h3;
  localparam logic [2:0]   BIT_LAST   = 3'h7;

  // Timing, in milliseconds, and the derived system clock counts.
  localparam int SYS_CLK_HZ           = 25_000_000;
  localparam int WRITE_CYCLE_MS       = 10;
  localparam int POWERUP_RESET_MS     = 200;
  localparam int WRITE_CYCLE_CYCLES   = WRITE_CYCLE_MS * (SYS_CLK_HZ / 1000);
  localparam int POWERUP_RESET_CYCLES = POWERUP_RESET_MS * (SYS_CLK_HZ / 1000);
  localparam int COUNT_W              = 24;

  // Internal nonvolatile write sequencer.
  typedef enum logic [1:0] {
    WR_IDLE,
    WR_COPY,
    WR_PROG
  } sep_wr_state_t;

endpackage

// [sep_spi_eeprom.sv]
// Serial command logic of a small SPI EEPROM with a protect-pin status lock.
// Assumes SCK, CS_N and SI come from an SPI master in mode 0 or 3, and that
// SCK stands still while CS_N is high.

module sep_spi_eeprom #(
  parameter int unsigned WRITE_CYCLES   = sep_pkg::WRITE_CYCLE_CYCLES,
  parameter int unsigned POWERUP_CYCLES = sep_pkg::POWERUP_RESET_CYCLES
) (
  input  wire logic                      SYS_CLK,
  input  wire logic                      RST_N,
  input  wire logic                      SCK,
  input  wire logic                      CS_N,
  input  wire logic                      SI,
  input  wire logic                      WP_N,
  output logic                           SO_OUT,
  output logic                           SO_OE,
  output logic                           RESET_OUT_N,
  output logic [sep_pkg::WD_W-1:0]       WATCHDOG_PERIOD,
  output logic                           WRITE_BUSY,
  output logic                           STATUS_LOCKED
);
  import sep_pkg::*;

  localparam int PAGE_BYTES = 1 << PAGE_ADDR_W;

  // True when the protect bits guard the given array address.
  function automatic logic is_guarded(input logic [1:0] bp, input logic [15:0] a);
    logic [15:0] am;
    am = {3'h0, a[ARRAY_ADDR_W-1:0]};
    case (bp)
      2'h1:    is_guarded = (am >= PROT_QTR_BASE);
      2'h2:    is_guarded = (am >= PROT_HALF_BASE);
      2'h3:    is_guarded = 1'b1;
      default: is_guarded = 1'b0;
    endcase
  endfunction

  // Next address: within the page for writes, across the whole array for reads.
  function automatic logic [15:0] next_addr(input logic [15:0] a, input logic in_page);
    logic [15:0] n;
    n = a;
    if (in_page) begin
      n[PAGE_ADDR_W-1:0] = a[PAGE_ADDR_W-1:0] + 1'b1;
    end else begin
      n[ARRAY_ADDR_W-1:0] = a[ARRAY_ADDR_W-1:0] + 1'b1;
    end
    next_addr = n;
  endfunction

  // System clock domain state.
  logic                  cs_s1_reg, cs_s2_reg, wp_s1_reg, wp_s2_reg;
  logic                  frame_clr_reg;
  logic [COUNT_W-1:0]    por_cnt_reg;
  logic                  por_done_reg;
  sep_wr_state_t         wr_state_reg;
  logic [COUNT_W-1:0]    wc_cnt_reg;
  logic [PAGE_ADDR_W-1:0] copy_idx_reg;
  logic [15:0]           page_reg;
  logic                  busy_reg, is_stat_reg, wel_reg, flag_reg;
  logic [7:0]            stat_pend_reg;
  logic                  lock_bit_reg, locked_reg;
  logic [1:0]            wd_reg, bp_reg;
  logic [7:0]            mem [0:(1<<ARRAY_ADDR_W)-1];

  // Link clock domain state.
  logic                  spi_rst_n;
  logic [2:0]            bit_cnt_reg;
  logic [1:0]            byte_cnt_reg;
  logic [7:0]            shift_reg, opcode_reg, stat_data_reg;
  logic [15:0]           addr_reg;
  logic                  data_seen_reg;
  logic [7:0]            st_s1_reg, st_s2_reg;
  logic [7:0]            pbuf_data [0:PAGE_BYTES-1];
  logic [PAGE_BYTES-1:0] pbuf_valid_reg;
  logic [7:0]            so_shift_reg;
  logic                  so_out_reg, so_oe_reg;

  logic [7:0]            in_next, status_byte, load_byte;
  logic                  byte_end, op_end, data_end, link_busy, load_now;
  logic                  cs_rise, cmd_ok, one_byte, lock_now;
  logic                  do_set_we, do_clr, do_set_flag, do_stat_wr, do_arr_wr, cycle_end;

  // The link logic is held while chip select is high, the hold starting only once the
  // system side has taken the frame result, so nothing is lost at the edge.
  assign spi_rst_n = RST_N & ~frame_clr_reg;

  assign status_byte = {lock_bit_reg, flag_reg, wd_reg, bp_reg, wel_reg, busy_reg};

  // Pin synchronisers on the system clock.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      wp_s1_reg <= 1'b1;
      wp_s2_reg <= 1'b1;
    end else begin
      cs_s1_reg <= CS_N;
      cs_s2_reg <= cs_s1_reg;
      wp_s1_reg <= WP_N;
      wp_s2_reg <= wp_s1_reg;
    end
  end

  // Frame clear follows the synchronised chip select; it also serves as the
  // previous value for spotting the rising edge.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      frame_clr_reg <= 1'b1;
    end else begin
      frame_clr_reg <= cs_s2_reg;
    end
  end

  // Reset output held active for the power-up time.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      por_cnt_reg  <= '0;
      por_done_reg <= 1'b0;
    end else if (!por_done_reg) begin
      por_cnt_reg  <= por_cnt_reg + 1'b1;
      por_done_reg <= (por_cnt_reg == COUNT_W'(POWERUP_CYCLES - 1));
    end
  end

  // Frame results are read only at the chip select rise, when SCK is idle and
  // the link registers are therefore static.
  assign cs_rise  = cs_s2_reg & ~frame_clr_reg;
  // Nothing but status reads is acted on while busy.
  assign cmd_ok   = cs_rise & por_done_reg & ~busy_reg;
  // Single-byte commands need exactly eight clocks.
  assign one_byte = (byte_cnt_reg == PH_ADDR_HI) && (bit_cnt_reg == 3'h0);
  assign do_set_we   = cmd_ok && one_byte && (opcode_reg == OP_SET_WE);
  assign do_clr      = cmd_ok && one_byte && (opcode_reg == OP_CLR_WE);
  assign do_set_flag = cmd_ok && one_byte && (opcode_reg == OP_SET_FLAG);
  // Lock state from lock bit and protect pin.
  assign lock_now = lock_bit_reg & ~wp_s2_reg;
  // Status write, exactly opcode plus one byte.
  assign do_stat_wr = cmd_ok && wel_reg && !lock_now && (opcode_reg == OP_STAT_WR) &&
                      (byte_cnt_reg == PH_ADDR_LO) && (bit_cnt_reg == 3'h0);
  // Array write needs a whole number of data bytes, at least one.
  assign do_arr_wr = cmd_ok && wel_reg && (opcode_reg == OP_WRITE) && data_seen_reg &&
                     (byte_cnt_reg == PH_DATA) && (bit_cnt_reg == 3'h0);
  assign cycle_end = (wr_state_reg == WR_PROG) &&
                     (wc_cnt_reg == COUNT_W'(WRITE_CYCLES - 1));

  // Internal write sequencer: copy the page buffer, then time the cycle.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_state_reg  <= WR_IDLE;
      wc_cnt_reg    <= '0;
      copy_idx_reg  <= '0;
      page_reg      <= '0;
      busy_reg      <= 1'b0;
      is_stat_reg   <= 1'b0;
      stat_pend_reg <= '0;
    end else begin
      case (wr_state_reg)
        WR_IDLE: begin
          wc_cnt_reg   <= '0;
          copy_idx_reg <= '0;
          if (do_arr_wr) begin
            // Busy for the whole internal cycle.
            busy_reg     <= 1'b1;
            is_stat_reg  <= 1'b0;
            page_reg     <= addr_reg;
            wr_state_reg <= WR_COPY;
          end else if (do_stat_wr) begin
            busy_reg      <= 1'b1;
            is_stat_reg   <= 1'b1;
            stat_pend_reg <= stat_data_reg;
            wr_state_reg  <= WR_PROG;
          end
        end
        WR_COPY: begin
          copy_idx_reg <= copy_idx_reg + 1'b1;
          if (copy_idx_reg == PAGE_ADDR_W'(PAGE_BYTES - 1)) begin
            wr_state_reg <= WR_PROG;
          end
        end
        WR_PROG: begin
          wc_cnt_reg <= wc_cnt_reg + 1'b1;
          if (cycle_end) begin
            busy_reg     <= 1'b0;
            wr_state_reg <= WR_IDLE;
          end
        end
        default: begin
          busy_reg     <= 1'b0;
          wr_state_reg <= WR_IDLE;
        end
      endcase
    end
  end

  // Guarded bytes are skipped while the page is written back.
  always_ff @(posedge SYS_CLK) begin
    if ((wr_state_reg == WR_COPY) && pbuf_valid_reg[copy_idx_reg] &&
        !is_guarded(bp_reg, {page_reg[15:PAGE_ADDR_W], copy_idx_reg})) begin
      mem[{page_reg[ARRAY_ADDR_W-1:PAGE_ADDR_W], copy_idx_reg}] <= pbuf_data[copy_idx_reg];
    end
  end

  // Write enable latch: set by its opcode, cleared by the clear opcode
  // and at the end of a valid write cycle.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wel_reg <= 1'b0;
    end else if (do_set_we) begin
      wel_reg <= 1'b1;
    end else if (do_clr || cycle_end) begin
      wel_reg <= 1'b0;
    end
  end

  // Volatile reset-cause flag; the status write also carries it.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flag_reg <= 1'b0;
    end else if (do_set_flag) begin
      flag_reg <= 1'b1;
    end else if (do_clr) begin
      flag_reg <= 1'b0;
    end else if (do_stat_wr) begin
      flag_reg <= stat_data_reg[ST_FLAG];
    end
  end

  // Nonvolatile bits land at the end of the cycle; the lock was checked
  // at the start, so a pin change meanwhile does not stop this write.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lock_bit_reg <= NV_LOCK_RST;
      wd_reg       <= NV_WD_RST;
      bp_reg       <= NV_BP_RST;
    end else if (cycle_end && is_stat_reg) begin
      // Lock bit written as 1 locks as soon as the pin is low.
      lock_bit_reg <= stat_pend_reg[ST_LOCK];
      wd_reg       <= stat_pend_reg[ST_WD_HI:ST_WD_LO];
      bp_reg       <= stat_pend_reg[ST_BP_HI:ST_BP_LO];
    end
  end

  // Registered copy of the lock state for the STATUS_LOCKED output.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      locked_reg <= 1'b0;
    end else begin
      locked_reg <= lock_now;
    end
  end

  assign RESET_OUT_N     = por_done_reg;
  assign WRITE_BUSY      = busy_reg;
  assign STATUS_LOCKED   = locked_reg;
  assign WATCHDOG_PERIOD = wd_reg;

  // Link side: status is static between frames except at the end of a write cycle, when busy, WEL and the
  // nonvolatile bits move; all of it passes two flip-flops before the output shifter sees it.
  always_ff @(posedge SCK or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      st_s1_reg <= '0;
      st_s2_reg <= '0;
    end else begin
      st_s1_reg <= status_byte;
      st_s2_reg <= st_s1_reg;
    end
  end

  assign link_busy = st_s2_reg[ST_BUSY];
  assign in_next   = {shift_reg[6:0], SI};
  assign byte_end  = (bit_cnt_reg == BIT_LAST);
  assign op_end    = byte_end && (byte_cnt_reg == PH_OPCODE);
  assign data_end  = byte_end && (byte_cnt_reg == PH_DATA);

  // Input bits taken on rising SCK, MSB first.
  always_ff @(posedge SCK or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      bit_cnt_reg   <= '0;
      byte_cnt_reg  <= PH_OPCODE;
      shift_reg     <= '0;
      opcode_reg    <= '0;
      stat_data_reg <= '0;
      addr_reg      <= '0;
      data_seen_reg <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
      shift_reg   <= in_next;
      if (byte_end) begin
        // Byte count saturates in the data phase.
        if (byte_cnt_reg != PH_DATA) begin
          byte_cnt_reg <= byte_cnt_reg + 1'b1;
        end
        case (byte_cnt_reg)
          PH_OPCODE:  opcode_reg <= in_next;
          PH_ADDR_HI: begin
            // Address high byte; a status write takes its data here.
            addr_reg[15:8] <= in_next;
            stat_data_reg  <= in_next;
          end
          PH_ADDR_LO: addr_reg[7:0] <= in_next;
          default: begin
            data_seen_reg <= 1'b1;
            // Read address moves on after each byte; wraps to zero.
            // Write address wraps inside the page.
            addr_reg <= next_addr(addr_reg, opcode_reg == OP_WRITE);
          end
        endcase
      end
    end
  end

  // Page buffer indexed by the low address bits. It is left untouched
  // while busy so the copy in progress reads stable data.
  always_ff @(posedge SCK or negedge RST_N) begin
    if (!RST_N) begin
      pbuf_valid_reg <= '0;
    end else if (!link_busy) begin
      if (op_end && (in_next == OP_WRITE)) begin
        pbuf_valid_reg <= '0;
      end else if (data_end && (opcode_reg == OP_WRITE)) begin
        pbuf_valid_reg[addr_reg[PAGE_ADDR_W-1:0]] <= 1'b1;
      end
    end
  end

  // Page buffer data, written alongside its valid bit.
  always_ff @(posedge SCK) begin
    if (!link_busy && data_end && (opcode_reg == OP_WRITE)) begin
      pbuf_data[addr_reg[PAGE_ADDR_W-1:0]] <= in_next;
    end
  end

  // Status repeats every byte after its opcode; array bytes follow the
  // address. The array is not read during a write cycle, so all ones show.
  assign load_now = (bit_cnt_reg == 3'h0) &&
                    (((opcode_reg == OP_STAT_RD) && (byte_cnt_reg != PH_OPCODE)) ||
                     ((opcode_reg == OP_READ) && (byte_cnt_reg == PH_DATA)));
  assign load_byte = (opcode_reg == OP_STAT_RD) ? st_s2_reg :
                     (link_busy ? 8'hff : mem[addr_reg[ARRAY_ADDR_W-1:0]]);

  // Output changes on falling SCK. Chip select high
  // asserts the frame reset, which floats the output.
  always_ff @(negedge SCK or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      so_shift_reg <= '0;
      so_out_reg   <= 1'b0;
      so_oe_reg    <= 1'b0;
    end else if (load_now) begin
      so_out_reg   <= load_byte[7];
      so_shift_reg <= {load_byte[6:0], 1'b0};
      so_oe_reg    <= 1'b1;
    end else if (so_oe_reg) begin
      so_out_reg   <= so_shift_reg[7];
      so_shift_reg <= {so_shift_reg[6:0], 1'b0};
    end
  end

  assign SO_OUT = so_out_reg;
  assign SO_OE  = so_oe_reg;

endmodule

// [sep_props.sv]
// Port-level checks for the SPI EEPROM command block.
// Assumes SYS_CLK is the checking clock; SPI pins are seen as sampled levels.
module sep_props #(
  parameter int unsigned WRITE_CYCLES   = 20,
  parameter int unsigned POWERUP_CYCLES = 10
) (
  input wire logic       SYS_CLK,
  input wire logic       RST_N,
  input wire logic       SCK,
  input wire logic       CS_N,
  input wire logic       SI,
  input wire logic       WP_N,
  input wire logic       SO_OUT,
  input wire logic       SO_OE,
  input wire logic       RESET_OUT_N,
  input wire logic [1:0] WATCHDOG_PERIOD,
  input wire logic       WRITE_BUSY,
  input wire logic       STATUS_LOCKED
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  int unsigned up_cnt_reg;
  int unsigned busy_cnt_reg;

  // Edges since reset release (saturating) and length of the running busy spell.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      up_cnt_reg <= 0;
      busy_cnt_reg <= 0;
    end else begin
      if (up_cnt_reg < POWERUP_CYCLES + 8) up_cnt_reg <= up_cnt_reg + 1;
      busy_cnt_reg <= WRITE_BUSY ? busy_cnt_reg + 1 : 0;
    end
  end

  sequence s_cs_idle;
    CS_N [*6];
  endsequence
  sequence s_busy_end;
    $fell(WRITE_BUSY);
  endsequence

  property p_rst_hold; (up_cnt_reg < POWERUP_CYCLES) |-> !RESET_OUT_N; endproperty
  property p_rst_rel; (up_cnt_reg > POWERUP_CYCLES + 3) |-> RESET_OUT_N; endproperty
  property p_rst_stay; RESET_OUT_N |=> RESET_OUT_N; endproperty
  property p_so_float; s_cs_idle |-> !SO_OE; endproperty
  property p_so_sel; $rose(SO_OE) |-> !CS_N; endproperty
  property p_busy_start; $rose(WRITE_BUSY) |-> CS_N && $past(CS_N); endproperty
  property p_busy_len;
    s_busy_end |-> busy_cnt_reg >= WRITE_CYCLES && busy_cnt_reg <= WRITE_CYCLES + 40;
  endproperty
  property p_wd_commit; !$fell(WRITE_BUSY) |-> $stable(WATCHDOG_PERIOD); endproperty
  property p_unlock; WP_N [*5] |-> !STATUS_LOCKED; endproperty
  property p_lock_src; $rose(STATUS_LOCKED) |-> !WP_N; endproperty

  a_rst_hold: assert property (p_rst_hold) else $error("reset out released early");
  a_rst_rel: assert property (p_rst_rel) else $error("reset out held too long");
  a_rst_stay: assert property (p_rst_stay) else $error("reset out fell");
  a_so_float: assert property (p_so_float) else $error("SO driven when idle");
  a_so_sel: assert property (p_so_sel) else $error("SO driven unselected");
  a_busy_start: assert property (p_busy_start) else $error("busy without cs rise");
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  a_wd_commit: assert property (p_wd_commit) else $error("watchdog bits moved");
  a_unlock: assert property (p_unlock) else $error("locked with pin high");
  a_lock_src: assert property (p_lock_src) else $error("locked with pin high");
endmodule

bind sep_spi_eeprom sep_props #(
  .WRITE_CYCLES  (WRITE_CYCLES),
  .POWERUP_CYCLES(POWERUP_CYCLES)
) props_u (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .SCK(SCK), .CS_N(CS_N), .SI(SI), .WP_N(WP_N),
  .SO_OUT(SO_OUT), .SO_OE(SO_OE), .RESET_OUT_N(RESET_OUT_N),
  .WATCHDOG_PERIOD(WATCHDOG_PERIOD), .WRITE_BUSY(WRITE_BUSY),
  .STATUS_LOCKED(STATUS_LOCKED)
);

// [sep_host.sv]
// Behavioural SPI master (mode 0, or mode 3 when cpol is set) for the host.
// Assumes the caller spaces frames; the serial clock runs only inside frames.
module sep_host (
  output logic      SCK,
  output logic      CS_N,
  output logic      SI,
  input wire logic  SO_OUT,
  input wire logic  SO_OE
);
  timeunit 1ns;
  timeprecision 1ps;

  // Clock idle level: 0 gives mode 0, 1 gives mode 3.
  logic cpol;

  // Idle bus: deselected, clock low.
  initial begin
    cpol = 1'b0;
    SCK = 1'b0;
    CS_N = 1'b1;
    SI = 1'b0;
  end

  // MSB-first frames. frame ends on chip select.
  task automatic frame(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
    rx = '0;
    // The idle level only moves while deselected, when the link is held.
    SCK = cpol;
    CS_N = 1'b0;
    #300;
    for (int i = 0; i < nbits; i++) begin
      // In mode 3 the data moves on the falling edge, never with a rising one.
      if (cpol) begin
        #6 SCK = 1'b0;
      end
      SI = tx[63-i];
      #6 SCK = 1'b1;
      // An undriven output reads as unknown so a floating answer never matches.
      rx = {rx[62:0], SO_OE ? SO_OUT : 1'bx};
      if (!cpol) begin
        #6 SCK = 1'b0;
      end
    end
    #300 CS_N = 1'b1;
    SI = ~SI;
    #600;
  endtask
endmodule

// [tb.sv]
// Self-checking bench for the SPI EEPROM command block.
// Assumes sep_host drives the link; short write and power-up counts are used.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sep_pkg::*;
  // Long enough that a whole command frame fits inside one write cycle.
  localparam int unsigned WCYC = 60;
  localparam int unsigned PCYC = 10;
  logic            sys_clk, rst_n, wp_n, sck, cs_n, si, so_out, so_oe;
  logic            reset_out_n, write_busy, status_locked;
  logic [WD_W-1:0] wd;
  logic [63:0]     rx;
  int              n_errors, cmp_count;

  sep_spi_eeprom #(.WRITE_CYCLES(WCYC), .POWERUP_CYCLES(PCYC)) dut_u (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .SCK(sck), .CS_N(cs_n), .SI(si), .WP_N(wp_n),
    .SO_OUT(so_out), .SO_OE(so_oe), .RESET_OUT_N(reset_out_n), .WATCHDOG_PERIOD(wd),
    .WRITE_BUSY(write_busy), .STATUS_LOCKED(status_locked));
  sep_host host_u (.SCK(sck), .CS_N(cs_n), .SI(si), .SO_OUT(so_out), .SO_OE(so_oe));

  // System clock at 25 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task finish_test;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task clks(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Busy may run long; the bound keeps a stuck flag from hanging the run.
  task wait_idle;
    int i;
    clks(4);
    i = 0;
    while (write_busy !== 1'b0 && i < 400) begin
      clks(1);
      i++;
    end
    if (i == 400) begin
      chk(8'h1, 8'h0);
      finish_test();
    end
  endtask
  task frm(input logic [63:0] tx, input int n);
    host_u.frame(tx, n, rx);
  endtask
  task stat(input logic [7:0] exp);
    frm({OP_STAT_RD, 56'h0}, 16);
    chk(rx[7:0], exp);
  endtask
  task rd(input logic [15:0] a);
    frm({OP_READ, a, 40'h0}, 48);
  endtask
  task wr(input logic [15:0] a, input logic [23:0] d, input int n);
    frm({OP_SET_WE, 56'h0}, 8);
    frm({OP_WRITE, a, d, 16'h0}, n);
  endtask
  task sr_write(input logic [7:0] d, input logic [1:0] exp_wd);
    frm({OP_SET_WE, 56'h0}, 8);
    frm({OP_STAT_WR, d, 48'h0}, 16);
    wait_idle();
    chk({6'h0, wd}, {6'h0, exp_wd});
  endtask
  task setwp(input logic v);
    @(posedge sys_clk);
    wp_n <= v;
    clks(6);
  endtask

  task t_power_up;
    chk({5'h0, reset_out_n, so_oe, write_busy}, 8'h0);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    clks(2);
    chk({7'h0, reset_out_n}, 8'h0);
    clks(PCYC + 4);
    chk({6'h0, reset_out_n, so_oe}, 8'h2);
    stat(8'h00);
  endtask
  task t_latch_cmds;
    frm({OP_SET_WE, 56'h0}, 8);
    stat(8'h02);
    frm({OP_SET_FLAG, 56'h0}, 8);
    stat(8'h42);
    frm({OP_CLR_WE, 56'h0}, 8);
    stat(8'h00);
    frm({OP_SET_WE, OP_WRITE, 16'h0040, 8'h99, 24'h0}, 40);
    clks(4);
    chk({7'h0, write_busy}, 8'h0);
    stat(8'h00);
  endtask
  task t_page_write;
    wr(16'h0000, 24'h5a0000, 32);
    frm({OP_STAT_RD, 56'h0}, 16);
    chk(rx[7:0] & 8'h01, 8'h01);
    // A flag command while busy must have no effect.
    frm({OP_SET_FLAG, 56'h0}, 8);
    wait_idle();
    stat(8'h00);
    wr(16'h1ffe, 24'h112233, 48);
    wait_idle();
    rd(16'h1ffe);
    chk(rx[23:16], 8'h11);
    chk(rx[15:8], 8'h22);
    chk(rx[7:0], 8'h5a);
    rd(16'h1fe0);
    chk(rx[23:16], 8'h33);
  endtask
  task t_mode3;
    host_u.cpol = 1'b1;
    rd(16'h1ffe);
    chk(rx[23:16], 8'h11);
    chk(rx[15:8], 8'h22);
    frm({OP_SET_WE, 56'h0}, 8);
    stat(8'h02);
    frm({OP_CLR_WE, 56'h0}, 8);
    stat(8'h00);
    host_u.cpol = 1'b0;
  endtask
  task t_refused;
    // Opcode and address only, no data byte.
    wr(16'h0000, 24'h770000, 24);
    clks(4);
    chk({7'h0, write_busy}, 8'h0);
    wr(16'h0000, 24'h770000, 36);
    clks(4);
    chk({7'h0, write_busy}, 8'h0);
    frm({OP_CLR_WE, 56'h0}, 8);
    frm({OP_WRITE, 16'h0000, 8'h77, 32'h0}, 32);
    clks(4);
    chk({7'h0, write_busy}, 8'h0);
    sr_write(8'h0c, 2'h0);
    stat(8'h0c);
    wr(16'h0000, 24'h770000, 32);
    wait_idle();
    rd(16'h0000);
    chk(rx[23:16], 8'h5a);
  endtask
  task t_lock;
    sr_write(8'h90, 2'h1);
    setwp(1'b0);
    chk({7'h0, status_locked}, 8'h1);
    sr_write(8'h00, 2'h1);
    setwp(1'b1);
    chk({7'h0, status_locked}, 8'h0);
    sr_write(8'h20, 2'h2);
    setwp(1'b0);
    sr_write(8'h30, 2'h3);
    sr_write(8'h90, 2'h1);
    sr_write(8'h00, 2'h1);
    setwp(1'b1);
    frm({OP_SET_WE, 56'h0}, 8);
    frm({OP_STAT_WR, 8'ha0, 48'h0}, 16);
    @(posedge sys_clk);
    wp_n <= 1'b0;
    wait_idle();
    chk({6'h0, wd}, 8'h02);
    sr_write(8'h00, 2'h2);
  endtask

  // Main sequence: reset held for 16 cycles, then each scenario in turn.
  initial begin
    n_errors = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    wp_n = 1'b1;
    clks(16);
    t_power_up();
    t_latch_cmds();
    t_page_write();
    t_mode3();
    t_refused();
    t_lock();
    finish_test();
  end
endmodule
